// file: inc/rsrb_params.svh
// constants for the relay state readback register bank
`ifndef RSRB_PARAMS_SVH
`define RSRB_PARAMS_SVH
// -----------------------------------------------------------------------------
// readback sequence
// -----------------------------------------------------------------------------
`define RSRB_NUM_REGS        24
`define RSRB_FIRST_IDX       5'h01
`define RSRB_IDX_ACT         5'h08
`define RSRB_IDX_MUX         5'h09
`define RSRB_IDX_PAIR        5'h0A
`define RSRB_IDX_MAP0        5'h0B
`define RSRB_IDX_MAP5        5'h10
`define RSRB_IDX_FUNC        5'h11
`define RSRB_IDX_RANGE       5'h12
`define RSRB_LAST_IDX        5'h18
// -----------------------------------------------------------------------------
// field layout
// -----------------------------------------------------------------------------
`define RSRB_ACT_BITS        6
`define RSRB_RELAY_CHANS     30
`define RSRB_MAP_BITS        5
`define RSRB_NO_CHAN         4'hF
`define RSRB_UNDEF_FILL      1'b0
`define RSRB_ZERO_BYTE       8'h00
// -----------------------------------------------------------------------------
// decimal conversion
// -----------------------------------------------------------------------------
`define RSRB_HUNDRED         8'h64
`define RSRB_TEN             8'h0A
`define RSRB_ASCII_ZERO      8'h30
// -----------------------------------------------------------------------------
// stream punctuation
// -----------------------------------------------------------------------------
`define RSRB_SEP_CH          8'h2C
`define RSRB_EOL_CH          8'h0A
`endif

// file: inc/rsrb_pkg.sv
// types for the relay state readback register bank
package rsrb_pkg;
	// readback sequencer states
	typedef enum logic [2:0] {
		RSRB_IDLE,
		RSRB_LOAD,
		RSRB_HUND,
		RSRB_TENS,
		RSRB_ONES,
		RSRB_SEP
	} rsrb_state_t;
	// measurement function codes
	typedef enum logic [2:0] {
		RSRB_FN_NONE,
		RSRB_FN_DCV,
		RSRB_FN_ACV,
		RSRB_FN_OHM2,
		RSRB_FN_OHM4,
		RSRB_FN_REFT,
		RSRB_FN_TEMP,
		RSRB_FN_FREQ
	} rsrb_func_t;
endpackage

// file: logic/rsrb_dec_digits.sv
// splits an 8-bit value into three ascii decimal digits
`timescale 1ns/100ps
`include "rsrb_params.svh"
module rsrb_dec_digits
	import rsrb_pkg::*;
(
	// value in
	input  wire logic [7:0] value,
	// ascii digits out
	output logic      [7:0] hund_ch,
	output logic      [7:0] tens_ch,
	output logic      [7:0] ones_ch
);
	logic [7:0] rem_v; // remainder after hundreds
	logic [7:0] h_v;   // hundreds digit
	logic [7:0] t_v;   // tens digit
	// ---------------------------------------------------------------------
	// combinational split into hundreds, tens and ones
	// ---------------------------------------------------------------------
	always_comb begin
		h_v   = value / `RSRB_HUNDRED;
		rem_v = value - 8'(h_v * `RSRB_HUNDRED);
		t_v   = rem_v / `RSRB_TEN;
		hund_ch = h_v + `RSRB_ASCII_ZERO;
		tens_ch = t_v + `RSRB_ASCII_ZERO;
		ones_ch = 8'(rem_v - 8'(t_v * `RSRB_TEN)) + `RSRB_ASCII_ZERO;
	end
endmodule

// file: logic/rsrb_regs.sv
// relay state readback register bank with decimal readback streamer
`timescale 1ns/100ps
`include "rsrb_params.svh"
module rsrb_regs
	import rsrb_pkg::*;
#(
	parameter int ACT_BITS    = `RSRB_ACT_BITS,
	parameter int RELAY_CHANS = `RSRB_RELAY_CHANS
) (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   resetn,
	// relay and measurement state from the control core
	input  wire logic [ACT_BITS-1:0]    actuator_closed,
	input  wire logic                   mux_closed,
	input  wire logic [1:0]             mux_slot,
	input  wire logic [3:0]             mux_chan,
	input  wire logic                   pair_closed,
	input  wire logic [1:0]             pair_slot,
	input  wire logic [3:0]             pair_chan,
	input  wire logic [RELAY_CHANS-1:0] relay_close_command_map,
	input  wire rsrb_func_t             meas_func,
	input  wire logic [7:0]             meas_range,
	// bytes of registers kept elsewhere, indexed by register number
	input  wire logic [7:0]             ext_reg_data,
	// command interface
	input  wire logic                   state_readback_command,
	input  wire logic                   other_command,
	// character stream to the bus interface
	input  wire logic                   tx_ready,
	output logic                        tx_valid,
	output logic [7:0]                  tx_char,
	output logic                        tx_busy,
	output logic [4:0]                  ext_reg_idx
);
	// ---------------------------------------------------------------------
	// state
	// ---------------------------------------------------------------------
	typedef struct packed {
		rsrb_state_t st;    // sequencer state
		logic [4:0]  idx;   // register number being sent
		logic [7:0]  val;   // latched register value
		logic        valid; // character offered
		logic [7:0]  ch;    // character
		logic        busy;  // stream in progress
	} rsrb_regs_t;
	rsrb_regs_t r_q;     // registered state
	rsrb_regs_t r_d;     // next state
	logic [7:0] sel_v;   // selected register value
	logic [7:0] hund_ch; // ascii hundreds
	logic [7:0] tens_ch; // ascii tens
	logic [7:0] ones_ch; // ascii ones
	logic       adv;     // character accepted
	logic [7:0] dec_in;  // value split into digits
	// ---------------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------------
	// address byte: slot in 5-4, channel in 3-0, channel all ones if open
	function automatic logic [7:0] addr_byte(input logic cl, input logic [1:0] sl, input logic [3:0] ch);
		logic [7:0] b;
		b = {`RSRB_UNDEF_FILL, `RSRB_UNDEF_FILL, sl, ch};
		if (!cl) begin
			b[3:0] = `RSRB_NO_CHAN;
		end
		return b;
	endfunction
	// bitmap byte k: five channels per byte, ascending
	function automatic logic [7:0] map_byte(input logic [RELAY_CHANS-1:0] m, input logic [4:0] k);
		logic [7:0] b;
		b = `RSRB_ZERO_BYTE;
		for (int i = 0; i < `RSRB_MAP_BITS; i++) begin
			if (int'(k) * `RSRB_MAP_BITS + i < RELAY_CHANS) begin
				b[i] = m[int'(k) * `RSRB_MAP_BITS + i];
			end
		end
		return b;
	endfunction
	// ---------------------------------------------------------------------
	// register select; pure read with no side effect on stored state
	// ---------------------------------------------------------------------
	always_comb begin
		sel_v = ext_reg_data;
		if (r_q.idx == `RSRB_IDX_ACT) begin
			sel_v = {2'(`RSRB_ZERO_BYTE), actuator_closed};
		end else if (r_q.idx == `RSRB_IDX_MUX) begin
			sel_v = addr_byte(mux_closed, mux_slot, mux_chan);
		end else if (r_q.idx == `RSRB_IDX_PAIR) begin
			sel_v = addr_byte(pair_closed, pair_slot, pair_chan);
		end else if (r_q.idx >= `RSRB_IDX_MAP0 && r_q.idx <= `RSRB_IDX_MAP5) begin
			sel_v = map_byte(relay_close_command_map, 5'(r_q.idx - `RSRB_IDX_MAP0));
		end else if (r_q.idx == `RSRB_IDX_FUNC) begin
			sel_v = {5'(`RSRB_ZERO_BYTE), meas_func};
		end else if (r_q.idx == `RSRB_IDX_RANGE) begin
			sel_v = meas_range;
		end
	end
	// digits come from the selected value during load, so the first
	// character offered already belongs to the new register
	assign dec_in = (r_q.st == RSRB_LOAD) ? sel_v : r_q.val;
	// decimal digits of the selected value in load, else of the latched value
	rsrb_dec_digits u_dec (
		.value   (dec_in),
		.hund_ch (hund_ch),
		.tens_ch (tens_ch),
		.ones_ch (ones_ch)
	);
	assign adv = r_q.valid && tx_ready;
	// ---------------------------------------------------------------------
	// sequencer next state
	// ---------------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		unique case (r_q.st)
			RSRB_IDLE: begin
				if (state_readback_command) begin
					r_d.idx = `RSRB_FIRST_IDX;
					r_d.st  = RSRB_LOAD;
				end
			end
			RSRB_LOAD: begin
				// latch value, offer hundreds digit
				r_d.val   = sel_v;
				r_d.st    = RSRB_HUND;
				r_d.valid = 1'b1;
				r_d.ch    = hund_ch;
			end
			RSRB_HUND: begin
				r_d.ch = hund_ch;
				if (adv) begin
					r_d.ch = tens_ch;
					r_d.st = RSRB_TENS;
				end
			end
			RSRB_TENS: begin
				if (adv) begin
					r_d.ch = ones_ch;
					r_d.st = RSRB_ONES;
				end
			end
			RSRB_ONES: begin
				if (adv) begin
					r_d.ch = (r_q.idx == `RSRB_LAST_IDX) ? `RSRB_EOL_CH : `RSRB_SEP_CH;
					r_d.st = RSRB_SEP;
				end
			end
			RSRB_SEP: begin
				if (adv) begin
					r_d.valid = 1'b0;
					if (r_q.idx == `RSRB_LAST_IDX) begin
						r_d.st = RSRB_IDLE;
					end else begin
						r_d.idx = 5'(r_q.idx + 5'h01);
						r_d.st  = RSRB_LOAD;
					end
				end
			end
		endcase
		// another command abandons the remaining registers
		if (other_command && r_q.st != RSRB_IDLE) begin
			r_d.st    = RSRB_IDLE;
			r_d.valid = 1'b0;
		end
		// busy flag registered so the port comes from a flop
		r_d.busy = (r_d.st != RSRB_IDLE);
	end
	// ---------------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			r_q <= '{st: RSRB_IDLE, idx: `RSRB_FIRST_IDX, val: `RSRB_ZERO_BYTE, valid: 1'b0, ch: `RSRB_ZERO_BYTE,
				busy: 1'b0};
		end else begin
			r_q <= r_d;
		end
	end
	// outputs straight from flops
	assign tx_valid    = r_q.valid;
	assign tx_char     = r_q.ch;
	assign tx_busy     = r_q.busy;
	assign ext_reg_idx = r_q.idx;
endmodule

// file: dv/rsrb_chk_sva.sv
// assertions on the readback streamer ports
`timescale 1ns/100ps
module rsrb_chk (
	// clock, reset, commands
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       state_readback_command,
	input wire logic       other_command,
	// character stream
	input wire logic       tx_ready,
	input wire logic       tx_valid,
	input wire logic [7:0] tx_char,
	input wire logic       tx_busy,
	input wire logic [4:0] ext_reg_idx
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// idle command loads register one, first digit a cycle later
	start_load_a: assert property (!tx_busy && state_readback_command && !other_command
		|=> tx_busy && ext_reg_idx == 5'h01 && !tx_valid ##1 tx_valid) else $error("bad start");
	char_hold_a: assert property (tx_valid && !tx_ready && !other_command
		|=> tx_valid && $stable(tx_char)) else $error("char dropped");
	abort_stop_a: assert property (tx_busy && other_command |=> !tx_valid) else $error("no abort");
	idle_quiet_a: assert property (!tx_busy |-> !tx_valid) else $error("idle valid");
	char_set_a: assert property (tx_valid
		|-> tx_char inside {[8'h30:8'h39], 8'h2C, 8'h0A}) else $error("bad char");
	idx_step_a: assert property (tx_busy && $changed(ext_reg_idx) && ext_reg_idx != 5'h01
		|-> ext_reg_idx == $past(ext_reg_idx) + 5'h01) else $error("index skip");
	idx_range_a: assert property (tx_busy |-> ext_reg_idx inside {[5'h01:5'h18]}) else $error("index out");
	sep_gap_a: assert property (tx_valid && tx_ready && tx_char == 8'h2C |=> !tx_valid) else $error("no gap");
	// main scenarios
	start_c: cover property (!tx_busy && state_readback_command);
	abort_c: cover property (tx_busy && other_command);
	end_c: cover property (tx_valid && tx_ready && tx_char == 8'h0A);
endmodule
bind rsrb_regs rsrb_chk chk_i (.*);

// file: dv/rsrb_host_sink.sv
// host model: takes stream characters and rebuilds each decimal value
`timescale 1ns/100ps
module rsrb_host_sink (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       resetn,
	// stream from the device
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_char,
	input  wire logic       slow,
	output logic            tx_ready,
	// rebuilt values
	output logic [7:0]      val,
	output logic            got,
	output logic            last
);
	logic [9:0] acc; // decimal accumulator
	logic [1:0] cnt; // stall pattern
	// slow mode is ready on one cycle in four
	assign tx_ready = !slow || cnt == 2'h3;
	// digits accumulate; separator or line end hands the value on
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			acc <= 10'h000;
			cnt <= 2'h0;
			got <= 1'b0;
		end else begin
			cnt <= cnt + 2'h1;
			got <= 1'b0;
			if (tx_valid && tx_ready) begin
				if (tx_char == 8'h2C || tx_char == 8'h0A) begin
					val <= acc[7:0];
					got <= 1'b1;
					last <= tx_char == 8'h0A;
					acc <= 10'h000;
				end else begin
					acc <= acc * 10'h00A + {6'h00, tx_char[3:0]};
				end
			end
		end
	end
endmodule

// file: dv/tb_rsrb_regs.sv
// testbench for the relay state readback register bank
`timescale 1ns/100ps
module tb_rsrb_regs
	import rsrb_pkg::*;
;
	logic        mclk = 1'b0, resetn = 1'b0, state_readback_command = 1'b0, other_command = 1'b0;
	logic        mux_closed = 1'b0, pair_closed = 1'b0, slow = 1'b0;
	logic [5:0]  actuator_closed = 6'h00;
	logic [1:0]  mux_slot = 2'h0, pair_slot = 2'h0;
	logic [3:0]  mux_chan = 4'h0, pair_chan = 4'h0;
	logic [29:0] relay_close_command_map = 30'h0;
	logic [7:0]  meas_range = 8'h00, ext_reg_data, tx_char, val;
	rsrb_func_t  meas_func = RSRB_FN_NONE;
	logic        tx_ready, tx_valid, tx_busy, got, last;
	logic [4:0]  ext_reg_idx;
	int          err_total = 0, total_checks = 0, cyc = 0;
	// registers kept elsewhere answer with a value tied to their index
	assign ext_reg_data = {3'h0, ext_reg_idx} + 8'hE6;
	rsrb_regs uut (.*);
	rsrb_host_sink host (.*);
	always #4 mclk = ~mclk;
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
		total_checks++;
		if ((g & m) !== (e & m)) begin
			err_total++;
			$display("[ERR] %0t got %0h want %0h", $time, g, e);
		end
	endtask
	// expected register value from the state inputs
	function automatic logic [7:0] exp_reg(input int r);
		case (r)
			8: return {2'h0, actuator_closed};
			9: return mux_closed ? {2'h0, mux_slot, mux_chan} : 8'h0F;
			10: return pair_closed ? {2'h0, pair_slot, pair_chan} : 8'h0F;
			17: return {5'h00, meas_func};
			18: return meas_range;
			default: return (r > 10 && r < 17) ? {3'h0, relay_close_command_map[5*(r-11) +: 5]} : 8'(r) + 8'hE6;
		endcase
	endfunction
	// one full readback, every value compared
	task automatic readback();
		while (tx_busy !== 1'b0) @(posedge mclk);
		@(posedge mclk) #1 state_readback_command = 1'b1;
		@(posedge mclk) #1 state_readback_command = 1'b0;
		for (int r = 1; r <= 24; r++) begin
			do @(posedge mclk); while (got !== 1'b1);
			chk(val, exp_reg(r), (r == 9 && !mux_closed) || (r == 10 && !pair_closed) ? 8'h0F : 8'hFF);
		end
		chk({7'h0, last}, 8'h01, 8'hFF);
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		#1 resetn = 1'b1;
		// every function code, walking actuator and relay bits
		for (int f = 0; f < 8; f++) begin
			@(posedge mclk) #1 meas_func = rsrb_func_t'(f);
			mux_closed = f[0];
			pair_closed = f[1];
			slow = f[2];
			mux_slot = 2'(f % 3);
			pair_slot = 2'(2 - f % 3);
			mux_chan = 4'(f + 2);
			pair_chan = 4'(9 - f);
			actuator_closed = 6'(6'h01 << (f % 6));
			relay_close_command_map = 30'h20000031 << f;
			meas_range = 8'hA0 + 8'(f);
			readback();
			if (f == 0)
				readback();
		end
		// second command while busy is ignored, then abort
		@(posedge mclk) #1 state_readback_command = 1'b1;
		@(posedge mclk) #1 state_readback_command = 1'b0;
		repeat (6) @(posedge mclk);
		#1 state_readback_command = 1'b1;
		@(posedge mclk) #1 state_readback_command = 1'b0;
		chk({7'h0, tx_busy}, 8'h01, 8'hFF);
		other_command = 1'b1;
		@(posedge mclk) #1 other_command = 1'b0;
		repeat (3) @(posedge mclk);
		chk({7'h0, tx_busy}, 8'h00, 8'hFF);
		// reset in the middle of a stream, then a clean readback
		@(posedge mclk) #1 state_readback_command = 1'b1;
		@(posedge mclk) #1 state_readback_command = 1'b0;
		repeat (4) @(posedge mclk);
		#1 chk({7'h0, tx_valid}, 8'h01, 8'hFF);
		resetn = 1'b0;
		#1 chk({7'h0, tx_valid}, 8'h00, 8'hFF);
		chk({7'h0, tx_busy}, 8'h00, 8'hFF);
		chk({3'h0, ext_reg_idx}, 8'h01, 8'hFF);
		repeat (10) @(posedge mclk);
		#1 resetn = 1'b1;
		readback();
		report_and_stop();
	end
endmodule
